// >>> setup_bank_defs.vh
// register offsets, field positions and reset values of the setup configuration bank
`ifndef SETUP_BANK_DEFS_VH
`define SETUP_BANK_DEFS_VH

`define ADDR_W 7
`define DATA_W 16
`define SETUP_BASE 7'h19
`define SETUP_LAST 7'h20
`define SETUP_RESET 16'h0000
`define CHAN_BASE 7'h30
`define CHAN_RESET 11'h000
`define EXC1_MAG_MSB 15
`define EXC1_MAG_LSB 13
`define EXC0_MAG_MSB 12
`define EXC0_MAG_LSB 10
`define BURNOUT_MSB 9
`define BURNOUT_LSB 8
`define POS_REF_BUF_BIT 7
`define NEG_REF_BUF_BIT 6
`define REF_SEL_MSB 5
`define REF_SEL_LSB 4
`define GAIN_MSB 3
`define GAIN_LSB 1
`define BYPASS_BIT 0
`define EXC0_PIN_MSB 3
`define EXC0_PIN_LSB 0
`define EXC1_PIN_MSB 7
`define EXC1_PIN_LSB 4
`define SETUP_IDX_MSB 10
`define SETUP_IDX_LSB 8

`endif

// >>> setup_decode.v
// decodes one setup word into the analog front-end controls of a channel
`timescale 1ns/100ps
`include "setup_bank_defs.vh"

module setup_decode (
  // selected setup word
  input wire [15:0] setup_word,
  // decoded controls
  output wire [2:0] exc1_magnitude,
  output wire [2:0] exc0_magnitude,
  output wire [1:0] burnout_code,
  output wire pos_ref_buffer_on,
  output wire neg_ref_buffer_on,
  output wire [1:0] ref_select,
  output wire amp_bypass,
  output wire [7:0] amp_gain
);

  wire [2:0] amp_gain_code;

  assign exc1_magnitude = setup_word[`EXC1_MAG_MSB:`EXC1_MAG_LSB];
  assign exc0_magnitude = setup_word[`EXC0_MAG_MSB:`EXC0_MAG_LSB];
  assign burnout_code = setup_word[`BURNOUT_MSB:`BURNOUT_LSB];
  assign pos_ref_buffer_on = setup_word[`POS_REF_BUF_BIT];
  assign neg_ref_buffer_on = setup_word[`NEG_REF_BUF_BIT];
  assign ref_select = setup_word[`REF_SEL_MSB:`REF_SEL_LSB];
  assign amp_bypass = setup_word[`BYPASS_BIT];
  assign amp_gain_code = setup_word[`GAIN_MSB:`GAIN_LSB];
  // gain as a one-hot power of two; bypass forces unity regardless of the code
  assign amp_gain = amp_bypass ? 8'h01 : (8'h01 << amp_gain_code);

endmodule // setup_decode

// >>> setup_config_bank.v
// setup configuration register bank with per-channel excitation routing
//
// What this block does
// - channel low nibble routes excitation 0 pin
// - next nibble codes 5..15 route excitation 1
// - codes 0..4 route excitation 1 to pins 0..4
// - setup words at 0x19..0x20, reset zero
// - channel uses setup chosen by its index
// - bits 15:13 set excitation 1 magnitude
// - bits 12:10 set excitation 0 magnitude
// - bits 9:8 select burnout current
// - bit 7 enables positive reference buffer
// - bit 6 enables negative reference buffer
// - bits 5:4 select reference pair
// - bits 3:1 gain is two to code
// - bit 0 bypass forces unity gain
`timescale 1ns/100ps
`include "setup_bank_defs.vh"

module setup_config_bank #(
  parameter NUM_SETUPS = 8,
  parameter NUM_CHANNELS = 16,
  parameter PIN_COUNT = 16
) (
  // clock and reset
  input wire clk_sys,
  input wire reset_n,
  input wire clk_en,
  // register port
  input wire [6:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // conversion side
  input wire [3:0] conv_channel,
  input wire conv_start,
  // controls for the active conversion
  output reg [PIN_COUNT-1:0] exc0_pin_onehot,
  output reg [PIN_COUNT-1:0] exc1_pin_onehot,
  output reg [2:0] exc1_magnitude,
  output reg [2:0] exc0_magnitude,
  output reg [1:0] burnout_code,
  output reg pos_ref_buffer_on,
  output reg neg_ref_buffer_on,
  output reg [1:0] ref_select,
  output reg amp_bypass,
  output reg [7:0] amp_gain,
  output reg [2:0] active_setup
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  reg [15:0] setup_q [0:NUM_SETUPS-1];
  reg [10:0] chan_q [0:NUM_CHANNELS-1];
  reg [15:0] rdata_d;
  reg [15:0] sel_word;
  reg [10:0] sel_chan;

  wire [2:0] dec_exc1;
  wire [2:0] dec_exc0;
  wire [1:0] dec_burnout;
  wire dec_pbuf;
  wire dec_nbuf;
  wire [1:0] dec_ref;
  wire dec_bypass;
  wire [7:0] dec_gain;
  wire [2:0] sel_idx;
  // register port decode
  wire [6:0] setup_off;
  wire [6:0] chan_off;
  wire [2:0] setup_idx;
  wire [3:0] chan_idx;
  wire [1:0] wr_kind;
  wire [1:0] rd_kind;
  wire conv_take;
  wire [PIN_COUNT-1:0] exc0_pin_d;
  wire [PIN_COUNT-1:0] exc1_pin_d;

  // next values of the conversion controls
  reg [2:0] exc1_mag_d;
  reg [2:0] exc0_mag_d;
  reg [1:0] burnout_d;
  reg pos_buf_d;
  reg neg_buf_d;
  reg [1:0] ref_sel_d;
  reg bypass_d;
  reg [7:0] gain_d;
  reg [2:0] active_setup_d;

  // channel word layout, bits 15:11 read back as zero:
  //   [10:8] setup index, [7:4] excitation 1 pin, [3:0] excitation 0 pin
  localparam KIND_NONE = 2'h0;
  localparam KIND_SETUP = 2'h1;
  localparam KIND_CHAN = 2'h2;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function is_setup;
    input [6:0] a;
    begin
      is_setup = (a >= `SETUP_BASE) && (a <= `SETUP_LAST);
    end
  endfunction

  function is_chan;
    input [6:0] a;
    begin
      is_chan = (a >= `CHAN_BASE) && (a < `CHAN_BASE + NUM_CHANNELS);
    end
  endfunction

  // one decode serves the write and the read side, so the two never disagree
  function [1:0] addr_kind;
    input [6:0] a;
    begin
      if (is_setup(a)) begin
        addr_kind = KIND_SETUP;
      end else if (is_chan(a)) begin
        addr_kind = KIND_CHAN;
      end else begin
        addr_kind = KIND_NONE;
      end
    end
  endfunction

  // pin index is compared at full width so a PIN_COUNT above 16 never aliases
  function pin_match;
    input [3:0] code;
    input integer k;
    begin
      pin_match = ({28'h0000000, code} == k);
    end
  endfunction

  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  // offsets wrap outside their class; the kind gates every use of them
  assign setup_off = reg_addr - `SETUP_BASE;
  assign chan_off = reg_addr - `CHAN_BASE;
  assign setup_idx = setup_off[2:0];
  assign chan_idx = chan_off[3:0];
  assign wr_kind = (clk_en && reg_wr) ? addr_kind(reg_addr) : KIND_NONE;
  assign rd_kind = reg_rd ? addr_kind(reg_addr) : KIND_NONE;

  // ----------------------------------------------------------------
  // setup and channel registers
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_SETUPS; g = g + 1) begin : gen_setup
      always @(posedge clk_sys) begin
        if (!reset_n) begin
          setup_q[g] <= `SETUP_RESET;
        end else if (wr_kind == KIND_SETUP && setup_off == g) begin
          setup_q[g] <= reg_wdata;
        end
      end
    end
    for (g = 0; g < NUM_CHANNELS; g = g + 1) begin : gen_chan
      always @(posedge clk_sys) begin
        if (!reset_n) begin
          chan_q[g] <= `CHAN_RESET;
        end else if (wr_kind == KIND_CHAN && chan_off == g) begin
          chan_q[g] <= reg_wdata[10:0];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // read path, data one cycle after the strobe
  // ----------------------------------------------------------------
  always @* begin
    // unmapped addresses and idle cycles read as zero
    rdata_d = 16'h0000;
    case (rd_kind)
      KIND_SETUP: begin
        rdata_d = setup_q[setup_idx];
      end
      KIND_CHAN: begin
        rdata_d = {5'h00, chan_q[chan_idx]};
      end
      default: begin
        rdata_d = 16'h0000;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      reg_rdata <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // setup selection for a conversion
  // ----------------------------------------------------------------
  always @* begin
    sel_chan = chan_q[conv_channel];
  end

  assign sel_idx = sel_chan[`SETUP_IDX_MSB:`SETUP_IDX_LSB];

  always @* begin
    sel_word = setup_q[sel_idx];
  end

  setup_decode u_decode (
    .setup_word(sel_word),
    .exc1_magnitude(dec_exc1),
    .exc0_magnitude(dec_exc0),
    .burnout_code(dec_burnout),
    .pos_ref_buffer_on(dec_pbuf),
    .neg_ref_buffer_on(dec_nbuf),
    .ref_select(dec_ref),
    .amp_bypass(dec_bypass),
    .amp_gain(dec_gain)
  );

  // ----------------------------------------------------------------
  // excitation routing, two comparators per analog input pin, one per excitation
  // ----------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < PIN_COUNT; p = p + 1) begin : gen_pin
      assign exc0_pin_d[p] = pin_match(sel_chan[`EXC0_PIN_MSB:`EXC0_PIN_LSB], p);
      assign exc1_pin_d[p] = pin_match(sel_chan[`EXC1_PIN_MSB:`EXC1_PIN_LSB], p);
    end
  endgenerate

  // ----------------------------------------------------------------
  // conversion controls
  // ----------------------------------------------------------------
  // a conversion start with clk_en low is lost, as is any strobe then
  assign conv_take = clk_en && conv_start;

  // settings are latched at conversion start so a write mid-conversion waits
  always @* begin
    // hold by default; clk_en low also freezes the controls
    exc1_mag_d = exc1_magnitude;
    exc0_mag_d = exc0_magnitude;
    burnout_d = burnout_code;
    pos_buf_d = pos_ref_buffer_on;
    neg_buf_d = neg_ref_buffer_on;
    ref_sel_d = ref_select;
    bypass_d = amp_bypass;
    gain_d = amp_gain;
    active_setup_d = active_setup;
    if (conv_take) begin
      exc1_mag_d = dec_exc1;
      exc0_mag_d = dec_exc0;
      burnout_d = dec_burnout;
      pos_buf_d = dec_pbuf;
      neg_buf_d = dec_nbuf;
      ref_sel_d = dec_ref;
      bypass_d = dec_bypass;
      gain_d = dec_gain;
      active_setup_d = sel_idx;
    end
  end

  // no pin is routed after reset until the first conversion picks one
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      exc0_pin_onehot <= {PIN_COUNT{1'b0}};
      exc1_pin_onehot <= {PIN_COUNT{1'b0}};
    end else if (conv_take) begin
      exc0_pin_onehot <= exc0_pin_d;
      exc1_pin_onehot <= exc1_pin_d;
    end
  end

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      exc1_magnitude <= 3'h0;
      exc0_magnitude <= 3'h0;
      burnout_code <= 2'h0;
      pos_ref_buffer_on <= 1'b0;
      neg_ref_buffer_on <= 1'b0;
      ref_select <= 2'h0;
      amp_bypass <= 1'b0;
      // unity gain, not zero, is the reset state of the gain output
      amp_gain <= 8'h01;
      active_setup <= 3'h0;
    end else begin
      exc1_magnitude <= exc1_mag_d;
      exc0_magnitude <= exc0_mag_d;
      burnout_code <= burnout_d;
      pos_ref_buffer_on <= pos_buf_d;
      neg_ref_buffer_on <= neg_buf_d;
      ref_select <= ref_sel_d;
      amp_bypass <= bypass_d;
      amp_gain <= gain_d;
      active_setup <= active_setup_d;
    end
  end

endmodule // setup_config_bank

// >>> setup_config_bank_props.sv
// assertion checker for the setup configuration bank
`timescale 1ns/100ps
module setup_config_bank_chk #(
  parameter NUM_SETUPS = 8,
  parameter NUM_CHANNELS = 16,
  parameter PIN_COUNT = 16
) (
  // all ports of the bank
  input wire clk_sys, reset_n, clk_en, reg_wr, reg_rd, conv_start,
  input wire [6:0] reg_addr,
  input wire [15:0] reg_wdata, reg_rdata,
  input wire [PIN_COUNT-1:0] exc0_pin_onehot, exc1_pin_onehot,
  input wire [3:0] conv_channel,
  input wire [2:0] exc1_magnitude, exc0_magnitude, active_setup,
  input wire [1:0] burnout_code, ref_select,
  input wire pos_ref_buffer_on, neg_ref_buffer_on, amp_bypass,
  input wire [7:0] amp_gain
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire rd = clk_en && reg_rd;
  wire cs = clk_en && conv_start;
  wire setup_hit = reg_addr >= 7'h19 && reg_addr <= 7'h20;
  a_rdata_idle: assert property (clk_en && !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not cleared");
  a_write_readback: assert property (clk_en && reg_wr && setup_hit ##1 rd && !reg_wr
    && $stable(reg_addr) |=> reg_rdata == $past(reg_wdata, 2)) else $error("bad readback");
  a_unmapped_read: assert property (rd && !setup_hit && reg_addr[6:4] != 3'h3
    |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
  a_chan_upper_zero: assert property (rd && reg_addr[6:4] == 3'h3
    |=> reg_rdata[15:11] == 5'h00) else $error("channel word upper bits set");
  a_bypass_unity: assert property (amp_bypass |-> amp_gain == 8'h01)
    else $error("bypass gain not unity");
  a_gain_onehot: assert property ($onehot(amp_gain))
    else $error("gain not a power of two");
  a_pin_onehot: assert property ($onehot0(exc0_pin_onehot) && $onehot0(exc1_pin_onehot))
    else $error("more than one pin selected");
  a_conv_pins: assert property (cs |=> exc0_pin_onehot != 0 && exc1_pin_onehot != 0)
    else $error("no pin after conversion start");
  a_settings_hold: assert property (!cs |=> $stable({exc0_pin_onehot, exc1_pin_onehot,
    amp_gain, active_setup, ref_select})) else $error("settings moved without start");
  c_bypass: cover property (cs ##1 amp_bypass);
  c_last_setup: cover property (rd && reg_addr == 7'h20);
  c_top_channel: cover property (cs && conv_channel == 4'hf);
endmodule // setup_config_bank_chk

bind setup_config_bank setup_config_bank_chk #(.NUM_SETUPS(NUM_SETUPS),
  .NUM_CHANNELS(NUM_CHANNELS), .PIN_COUNT(PIN_COUNT)) i_chk (.*);

// >>> setup_config_bank_tb_top.sv
// self-checking testbench for the setup configuration bank
`timescale 1ns/100ps
module setup_config_bank_tb_top;
  reg clk_sys = 1'h0, reset_n = 1'h0, clk_en = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
  reg conv_start = 1'h0, rd_d = 1'h0, cs_d = 1'h0, e = 1'h1;
  reg [6:0] reg_addr = 7'h00;
  reg [15:0] reg_wdata = 16'h0000;
  reg [3:0] conv_channel = 4'h0;
  wire [15:0] reg_rdata, exc0_pin_onehot, exc1_pin_onehot;
  wire [2:0] exc1_magnitude, exc0_magnitude, active_setup;
  wire [1:0] burnout_code, ref_select;
  wire pos_ref_buffer_on, neg_ref_buffer_on, amp_bypass;
  wire [7:0] amp_gain;
  wire [55:0] conv_out = {exc0_pin_onehot, exc1_pin_onehot, exc1_magnitude, exc0_magnitude,
    burnout_code, pos_ref_buffer_on, neg_ref_buffer_on, ref_select, amp_bypass, amp_gain,
    active_setup};
  reg [15:0] sw [0:7];
  reg [10:0] cw [0:15];
  logic [55:0] rq [$];
  logic [55:0] cq [$];
  integer num_errors = 0, check_count = 0, seed = 32'h58664226, i, r;
  setup_config_bank i_dut (.*);
  always #5 clk_sys = ~clk_sys;
  // ----------------------------------------
  // driver: k 0 write, 1 read, 2 conversion, 3 idle
  // ----------------------------------------
  task op(input [1:0] k, input [6:0] a, input [15:0] d);
    reg [15:0] s;
    clk_en <= e;
    reg_wr <= k == 2'h0;
    reg_rd <= k == 2'h1;
    conv_start <= k == 2'h2;
    reg_addr <= a;
    reg_wdata <= d;
    conv_channel <= a[3:0];
    s = sw[cw[a[3:0]][10:8]];
    // clk_en low swallows the strobe, so the model must not move either
    if (e && k == 2'h1) rq.push_back(a >= 7'h19 && a <= 7'h20 ? sw[a - 7'h19] :
      a[6:4] == 3'h3 ? {5'h00, cw[a[3:0]]} : 16'h0000);
    if (e && k == 2'h0 && a >= 7'h19 && a <= 7'h20) sw[a - 7'h19] = d;
    if (e && k == 2'h0 && a[6:4] == 3'h3) cw[a[3:0]] = d[10:0];
    if (e && k == 2'h2) cq.push_back({16'h0001 << cw[a[3:0]][3:0],
      16'h0001 << cw[a[3:0]][7:4], s[15:4], s[0], (s[0] ? 8'h01 : 8'h01 << s[3:1]),
      cw[a[3:0]][10:8]});
    @(posedge clk_sys);
  endtask
  task chk(input [55:0] g, input [55:0] x);
    check_count++;
    if (g !== x) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task test_done;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------
  // monitor: results appear one cycle after the accepted strobe
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (rd_d) chk(reg_rdata, rq.pop_front());
    if (cs_d) chk(conv_out, cq.pop_front());
    rd_d <= reg_rd && clk_en && reset_n;
    cs_d <= conv_start && clk_en && reset_n;
  end
  initial begin
    for (r = 0; r < 2; r++) begin
      e = 1'h1;
      op(3, 7'h00, 16'h0000);
      reset_n <= 1'h0;
      // second pass resets in mid-run with registers already written
      repeat (r ? 2 : 15) @(posedge clk_sys);
      reset_n <= 1'h1;
      chk(conv_out, {32'h0, 12'h000, 1'b0, 8'h01, 3'h0});
      for (i = 0; i < 16; i++) begin
        sw[i[2:0]] = 16'h0000;
        cw[i] = 11'h000;
      end
      for (i = 0; i < 8; i++) op(1, 7'h19 + i[6:0], 16'h0000);
      for (i = 0; i < 8; i++) begin
        op(0, 7'h19 + i[6:0], $random(seed));
        op(1, 7'h19 + i[6:0], 16'h0000);
      end
      for (i = 0; i < 16; i++) begin
        op(0, 7'h30 + i[6:0], (15 - i) << 4 | i | $random(seed) & 16'h0700);
        op(2, i[6:0], 16'h0000);
      end
      op(0, 7'h30, 16'h0021);
      for (i = 0; i < 16; i++) begin
        op(0, 7'h19, $random(seed) & 16'hfff0 | i[3:0]);
        op(2, 7'h00, 16'h0000);
      end
      for (i = 0; i < 200; i++) begin
        e = {$random(seed)} % 4 != 0;
        op({$random(seed)} % 3, $random(seed), $random(seed));
      end
    end
    op(3, 7'h00, 16'h0000);
    repeat (3) @(posedge clk_sys);
    if (rq.size() + cq.size()) chk(56'h1, 56'h0);
    test_done;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    $display("ERROR %0t: run did not finish", $time);
    test_done;
  end
endmodule // setup_config_bank_tb_top
